// >>> rtl/nsb_device_end.sv
// Device end: trigger selection, LSB sync detection, per-converter oscillators,
// mixers with saturation, and the channel bonder for each output channel
// Assumes: every link signal comes from flip-flops of the source end on clk
`timescale 1ns/10ps
`include "nsb_cfg.svh"

module nsb_device_end #(
	parameter int N_DUC = 4,
	parameter int N_CH = 2
) (
	input wire logic clk,
	input wire logic rst,
	nsb_link_if.dev link,
	output nsb_pkg::nsb_sample_t [N_CH-1:0] out_i,
	output nsb_pkg::nsb_sample_t [N_CH-1:0] out_q,
	output logic out_valid,
	output logic sync_event,
	output logic lsb_replace_active
);
	import nsb_pkg::*;

	function automatic nsb_sample_t sat16(input logic signed [35:0] v);
		if (v > 36'sh000007FFF) begin
			sat16 = 16'h7FFF;
		end else if (v < 36'shFFFFF8000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	// a*b +/- c*d, product scale 2^15 back to unity
	function automatic logic signed [35:0] mac15(input nsb_sample_t a, input nsb_sample_t b,
		input nsb_sample_t c, input nsb_sample_t d, input logic sub);
		logic signed [35:0] p0;
		logic signed [35:0] p1;
		p0 = 36'(a * b);
		p1 = 36'(c * d);
		mac15 = (sub ? p0 - p1 : p0 + p1) >>> 15;
	endfunction : mac15

	function automatic logic signed [17:0] scale(input nsb_sample_t v, input nsb_gain_t g);
		logic signed [17:0] w;
		w = {v, 2'b00};
		case (g)
			2'h0: scale = w;
			2'h1: scale = w >>> 1;
			default: scale = w >>> 2;
		endcase
	endfunction : scale

	// Complex channels keep only the first two selected sources
	function automatic logic [N_DUC-1:0] limit_pick(input logic [N_DUC-1:0] mask, input logic cplx);
		logic [1:0] taken;
		limit_pick = '0;
		taken = 2'h0;
		for (int k = 0; k < N_DUC; k++) begin
			if (mask[k] && (!cplx || taken < 2'h2)) begin
				limit_pick[k] = 1'b1;
				taken = taken + 2'h1;
			end
		end
	endfunction : limit_pick

	logic sysref_d_reg;
	logic sw_sync_d_reg;
	logic cs_d_reg;
	logic replace_done_reg;
	logic [2:0] low_cnt_reg;
	logic [2:0] high_cnt_reg;
	logic synced_reg;
	nsb_freq_t coh_cnt_reg;
	logic valid_d_reg;
	nsb_sample_t [N_DUC-1:0] mix_i_reg;
	nsb_sample_t [N_DUC-1:0] mix_q_reg;
	nsb_sample_t [N_DUC-1:0] duc_i;
	nsb_sample_t [N_DUC-1:0] nco_sin;
	nsb_sample_t [N_DUC-1:0] nco_cos;
	logic [N_DUC-1:0] ar_eff;
	logic signed [19:0] bond_i [N_CH];
	logic signed [19:0] bond_q [N_CH];
	logic replace;
	logic sync_bit;
	logic high_step;
	logic lsb_fire;
	logic trig;

	assign replace = link.sw_sync && (link.trig_src == NSB_TRIG_LSB) && !replace_done_reg;
	assign sync_bit = link.i_smp[0][0];
	assign high_step = link.smp_valid && sync_bit && (low_cnt_reg == `NSB_SYNC_RUN || high_cnt_reg != 3'h0);
	assign lsb_fire = replace && high_step && (high_cnt_reg == `NSB_SYNC_RUN - 3'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_cnt_reg <= 3'h0;
		end else if (!replace || (link.smp_valid && sync_bit)) begin
			low_cnt_reg <= 3'h0;
		end else if (link.smp_valid && low_cnt_reg != `NSB_SYNC_RUN) begin
			low_cnt_reg <= low_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			high_cnt_reg <= 3'h0;
		end else if (!replace || (link.smp_valid && !sync_bit)) begin
			high_cnt_reg <= 3'h0;
		end else if (high_step && high_cnt_reg != `NSB_SYNC_RUN) begin
			high_cnt_reg <= high_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			replace_done_reg <= 1'b0;
		end else if (!link.sw_sync) begin
			replace_done_reg <= 1'b0;
		end else if (lsb_fire && link.fastcfg_enable) begin
			replace_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sysref_d_reg <= 1'b0;
			sw_sync_d_reg <= 1'b0;
			cs_d_reg <= 1'b0;
		end else begin
			sysref_d_reg <= link.sysref;
			sw_sync_d_reg <= link.sw_sync;
			cs_d_reg <= link.fastcfg_chip_select;
		end
	end

	always_comb begin
		unique case (link.trig_src)
			NSB_TRIG_SYSREF: trig = link.sysref && !sysref_d_reg;
			NSB_TRIG_SW: trig = link.sw_sync && !sw_sync_d_reg;
			NSB_TRIG_FASTCFG: trig = link.fastcfg_sync_enable && link.fastcfg_chip_select && !cs_d_reg;
			NSB_TRIG_LSB: trig = lsb_fire;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			synced_reg <= 1'b0;
			coh_cnt_reg <= '0;
		end else if (trig && !synced_reg) begin
			synced_reg <= 1'b1;
			coh_cnt_reg <= '0;
		end else begin
			coh_cnt_reg <= coh_cnt_reg + 64'h1;
		end
	end

	for (genvar n = 0; n < N_DUC; n++) begin : g_duc
		assign duc_i[n] = (n == 0 && replace) ? {link.i_smp[n][15:1], 1'b0} : link.i_smp[n];
		assign ar_eff[n] = link.fastcfg_enable ? link.fastcfg_accumulator_auto_reset[n] :
			link.accumulator_auto_reset[n];
		nsb_nco u_nco (
			.clk(clk),
			.rst(rst),
			.trig(trig),
			.freq_word(link.freq_word[n]),
			.phase_word(link.phase_word[n]),
			.cont(link.phase_continuous_select[n]),
			.auto_reset(ar_eff[n]),
			.coh_count(coh_cnt_reg),
			.sin_out(nco_sin[n]),
			.cos_out(nco_cos[n])
		);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mix_i_reg <= '0;
			mix_q_reg <= '0;
		end else begin
			for (int n = 0; n < N_DUC; n++) begin
				mix_i_reg[n] <= sat16(mac15(duc_i[n], nco_cos[n], link.q_smp[n], nco_sin[n], 1'b1));
				mix_q_reg[n] <= link.real_mode ? 16'h0000 :
					sat16(mac15(duc_i[n], nco_sin[n], link.q_smp[n], nco_cos[n], 1'b0));
			end
		end
	end

	always_comb begin
		logic [N_DUC-1:0] pick;
		pick = '0;
		for (int c = 0; c < N_CH; c++) begin
			pick = limit_pick(link.output_channel_source_select[c], !link.real_mode);
			bond_i[c] = 20'sh00000;
			bond_q[c] = 20'sh00000;
			for (int n = 0; n < N_DUC; n++) begin
				if (pick[n]) begin
					bond_i[c] = bond_i[c] + 20'(scale(mix_i_reg[n], link.upconverter_gain_select[n]));
					bond_q[c] = bond_q[c] + 20'(scale(mix_q_reg[n], link.upconverter_gain_select[n]));
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_i <= '0;
			out_q <= '0;
		end else begin
			for (int c = 0; c < N_CH; c++) begin
				out_i[c] <= sat16(36'((bond_i[c] + 20'sh00002) >>> 2));
				out_q[c] <= sat16(36'((bond_q[c] + 20'sh00002) >>> 2));
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valid_d_reg <= 1'b0;
			out_valid <= 1'b0;
			sync_event <= 1'b0;
			lsb_replace_active <= 1'b0;
		end else begin
			valid_d_reg <= link.smp_valid;
			out_valid <= valid_d_reg;
			sync_event <= trig;
			lsb_replace_active <= replace;
		end
	end
endmodule : nsb_device_end

// >>> rtl/nsb_nco.sv
// One oscillator: active frequency word, phase accumulator, coarse sine/cosine
// Assumes: trigger is a one-cycle pulse shared by all oscillators of the device
`timescale 1ns/10ps
module nsb_nco (
	input wire logic clk,
	input wire logic rst,
	input wire logic trig,
	input nsb_pkg::nsb_freq_t freq_word,
	input wire logic [15:0] phase_word,
	input wire logic cont,
	input wire logic auto_reset,
	input nsb_pkg::nsb_freq_t coh_count,
	output nsb_pkg::nsb_sample_t sin_out,
	output nsb_pkg::nsb_sample_t cos_out
);
	import nsb_pkg::*;

	localparam nsb_sample_t QTAB [0:8] = '{16'h0000, 16'h18F9, 16'h30FB, 16'h471C, 16'h5A82,
		16'h6A6D, 16'h7641, 16'h7D89, 16'h7FFF};

	function automatic nsb_sample_t sine(input logic [15:0] ph);
		logic [3:0] k;
		k = {1'b0, ph[13:11]};
		unique case (ph[15:14])
			2'h0: sine = QTAB[k];
			2'h1: sine = QTAB[4'h8 - k];
			2'h2: sine = -QTAB[k];
			2'h3: sine = -QTAB[4'h8 - k];
		endcase
	endfunction : sine

	nsb_freq_t freq_act_reg;
	nsb_freq_t acc_reg;
	nsb_freq_t freq_now;
	logic [15:0] phase;

	assign freq_now = trig ? freq_word : freq_act_reg;
	assign phase = acc_reg[63:48] + phase_word;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freq_act_reg <= '0;
		end else if (trig) begin
			freq_act_reg <= freq_word;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_reg <= '0;
		end else if (trig && auto_reset) begin
			acc_reg <= '0;
		end else if (cont) begin
			acc_reg <= acc_reg + freq_act_reg;
		end else begin
			acc_reg <= 64'(freq_now * coh_count);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sin_out <= '0;
			cos_out <= '0;
		end else begin
			sin_out <= sine(phase);
			cos_out <= sine(phase + 16'h4000);
		end
	end
endmodule : nsb_nco

// >>> rtl/nsb_source_end.sv
// Source/controller end: APB register slave that drives the link,
// sample stream with sync-bit pattern, SYSREF strobe and chip-select level
// Assumes: APB master on clk; device end listens on the same clk
`timescale 1ns/10ps
`include "nsb_cfg.svh"
module nsb_source_end #(
	parameter int N_DUC = 4,
	parameter int N_CH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pattern_busy,
	nsb_link_if.src link
);
	import nsb_pkg::*;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= `NSB_OFS_STATUS) && (a[1:0] == 2'h0);
	endfunction : mapped

	logic [15:0] ctrl_reg;
	logic [11:0] mode_reg;
	logic [7:0] gain_reg;
	logic [7:0] src_reg;
	logic [31:0] sample_reg;
	nsb_freq_t freq_reg [N_DUC];
	logic [15:0] phase_reg [N_DUC];
	nsb_pat_e pat_reg;
	logic [2:0] pat_cnt_reg;
	logic sysref_reg;
	logic valid_reg;
	logic [31:0] rdata_next;
	logic [1:0] idx;
	logic access;
	logic wr;

	assign idx = ctrl_reg[`NSB_CTRL_IDX_LSB +: 2];
	assign access = psel && penable && !pready;
	assign wr = psel && penable && pready && pwrite;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			prdata <= (access && !pwrite) ? rdata_next : 32'h0000_0000;
			pslverr <= access && !mapped(paddr);
		end
	end

	always_comb begin
		unique case (paddr)
			`NSB_OFS_CTRL: rdata_next = {16'h0000, ctrl_reg};
			`NSB_OFS_MODE: rdata_next = {20'h00000, mode_reg};
			`NSB_OFS_GAIN: rdata_next = {24'h000000, gain_reg};
			`NSB_OFS_SRC: rdata_next = {24'h000000, src_reg};
			`NSB_OFS_FREQ_LO: rdata_next = freq_reg[idx][31:0];
			`NSB_OFS_FREQ_HI: rdata_next = freq_reg[idx][63:32];
			`NSB_OFS_PHASE: rdata_next = {16'h0000, phase_reg[idx]};
			`NSB_OFS_SAMPLE: rdata_next = sample_reg;
			`NSB_OFS_STATUS: rdata_next = {29'h00000000, pat_reg != NSB_PAT_IDLE, pat_reg};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `NSB_CTRL_RST;
			mode_reg <= `NSB_MODE_RST;
			gain_reg <= `NSB_GAIN_RST;
			src_reg <= `NSB_SRC_RST;
			sample_reg <= 32'h0000_0000;
		end else if (wr) begin
			unique case (paddr)
				`NSB_OFS_CTRL: ctrl_reg <= pwdata[15:0];
				`NSB_OFS_MODE: mode_reg <= pwdata[11:0];
				`NSB_OFS_GAIN: gain_reg <= pwdata[7:0];
				`NSB_OFS_SRC: src_reg <= pwdata[7:0];
				`NSB_OFS_SAMPLE: sample_reg <= pwdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int n = 0; n < N_DUC; n++) begin
				freq_reg[n] <= '0;
				phase_reg[n] <= 16'h0000;
			end
		end else if (wr && paddr == `NSB_OFS_FREQ_LO) begin
			freq_reg[idx][31:0] <= pwdata;
		end else if (wr && paddr == `NSB_OFS_FREQ_HI) begin
			freq_reg[idx][63:32] <= pwdata;
		end else if (wr && paddr == `NSB_OFS_PHASE) begin
			phase_reg[idx] <= pwdata[15:0];
		end
	end

	// Single SYSREF pulse per request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sysref_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			sysref_reg <= wr && paddr == `NSB_OFS_CTRL && pwdata[`NSB_CTRL_SYSREF];
			valid_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pat_reg <= NSB_PAT_IDLE;
			pat_cnt_reg <= 3'h0;
			pattern_busy <= 1'b0;
		end else begin
			unique case (pat_reg)
				NSB_PAT_IDLE: begin
					if (wr && paddr == `NSB_OFS_CTRL && pwdata[`NSB_CTRL_PATTERN]) begin
						pat_reg <= NSB_PAT_LOW;
						pattern_busy <= 1'b1;
						pat_cnt_reg <= 3'h0;
					end
				end
				NSB_PAT_LOW: begin
					pat_cnt_reg <= (pat_cnt_reg == `NSB_SYNC_RUN - 3'h1) ? 3'h0 : pat_cnt_reg + 3'h1;
					if (pat_cnt_reg == `NSB_SYNC_RUN - 3'h1) begin
						pat_reg <= NSB_PAT_HIGH;
					end
				end
				NSB_PAT_HIGH: begin
					pat_cnt_reg <= pat_cnt_reg + 3'h1;
					if (pat_cnt_reg == `NSB_SYNC_RUN - 3'h1) begin
						pat_reg <= NSB_PAT_IDLE;
						pattern_busy <= 1'b0;
					end
				end
			endcase
		end
	end

	for (genvar n = 0; n < N_DUC; n++) begin : g_lane
		if (n == 0) begin : g_sync
			assign link.i_smp[n] = {sample_reg[15:1],
				(pat_reg == NSB_PAT_IDLE) ? sample_reg[0] : (pat_reg == NSB_PAT_HIGH)};
		end else begin : g_plain
			assign link.i_smp[n] = sample_reg[15:0];
		end
		assign link.q_smp[n] = sample_reg[31:16];
		assign link.freq_word[n] = freq_reg[n];
		assign link.phase_word[n] = phase_reg[n];
		assign link.upconverter_gain_select[n] = gain_reg[2*n +: 2];
	end

	for (genvar c = 0; c < N_CH; c++) begin : g_ch
		assign link.output_channel_source_select[c] = src_reg[4*c +: 4];
	end

	assign link.smp_valid = valid_reg;
	assign link.sysref = sysref_reg;
	assign link.sw_sync = ctrl_reg[`NSB_CTRL_SW_SYNC];
	assign link.trig_src = nsb_trig_e'(ctrl_reg[`NSB_CTRL_TRIG_LSB +: 2]);
	assign link.fastcfg_enable = ctrl_reg[`NSB_CTRL_FC_EN];
	assign link.fastcfg_sync_enable = ctrl_reg[`NSB_CTRL_FC_SYNC];
	assign link.fastcfg_chip_select = ctrl_reg[`NSB_CTRL_FC_CS];
	assign link.real_mode = ctrl_reg[`NSB_CTRL_REAL];
	assign link.phase_continuous_select = mode_reg[`NSB_MODE_CONT_LSB +: 4];
	assign link.accumulator_auto_reset = mode_reg[`NSB_MODE_AR_LSB +: 4];
	assign link.fastcfg_accumulator_auto_reset = mode_reg[`NSB_MODE_FRAR_LSB +: 4];
endmodule : nsb_source_end

// >>> shared/nsb_cfg.svh
// Offsets, field positions, reset values and counts for the update/sync/bonder pair
// Assumes: included by bare name; holds definitions only
`ifndef NSB_CFG_SVH
`define NSB_CFG_SVH
`define NSB_OFS_CTRL 8'h00
`define NSB_OFS_MODE 8'h04
`define NSB_OFS_GAIN 8'h08
`define NSB_OFS_SRC 8'h0C
`define NSB_OFS_FREQ_LO 8'h10
`define NSB_OFS_FREQ_HI 8'h14
`define NSB_OFS_PHASE 8'h18
`define NSB_OFS_SAMPLE 8'h1C
`define NSB_OFS_STATUS 8'h20
`define NSB_CTRL_TRIG_LSB 0
`define NSB_CTRL_SW_SYNC 2
`define NSB_CTRL_FC_EN 3
`define NSB_CTRL_FC_SYNC 4
`define NSB_CTRL_REAL 5
`define NSB_CTRL_FC_CS 6
`define NSB_CTRL_IDX_LSB 8
`define NSB_CTRL_SYSREF 16
`define NSB_CTRL_PATTERN 17
`define NSB_MODE_CONT_LSB 0
`define NSB_MODE_AR_LSB 4
`define NSB_MODE_FRAR_LSB 8
`define NSB_CTRL_RST 16'h0000
`define NSB_MODE_RST 12'h000
`define NSB_GAIN_RST 8'h00
`define NSB_SRC_RST 8'h21
`define NSB_SYNC_RUN 3'h4
`endif

// >>> shared/nsb_link_if.sv
// Link between the data source/controller end and the device end
// Assumes: both ends on the same clk; the source drives, the device listens
`timescale 1ns/10ps
interface nsb_link_if #(
	parameter int N_DUC = 4,
	parameter int N_CH = 2
) (
	input wire logic clk
);
	import nsb_pkg::*;
	nsb_sample_t [N_DUC-1:0] i_smp;
	nsb_sample_t [N_DUC-1:0] q_smp;
	logic smp_valid;
	logic sysref;
	logic sw_sync;
	nsb_trig_e trig_src;
	logic fastcfg_enable;
	logic fastcfg_sync_enable;
	logic fastcfg_chip_select;
	logic [N_DUC-1:0] fastcfg_accumulator_auto_reset;
	logic [N_DUC-1:0] phase_continuous_select;
	logic [N_DUC-1:0] accumulator_auto_reset;
	nsb_freq_t [N_DUC-1:0] freq_word;
	logic [N_DUC-1:0][15:0] phase_word;
	nsb_gain_t [N_DUC-1:0] upconverter_gain_select;
	logic real_mode;
	logic [N_CH-1:0][N_DUC-1:0] output_channel_source_select;
	modport dev (
		input i_smp, q_smp, smp_valid, sysref, sw_sync, trig_src, fastcfg_enable, fastcfg_sync_enable,
		input fastcfg_chip_select, fastcfg_accumulator_auto_reset, phase_continuous_select,
		input accumulator_auto_reset, freq_word, phase_word, upconverter_gain_select, real_mode,
		input output_channel_source_select
	);
	modport src (
		output i_smp, q_smp, smp_valid, sysref, sw_sync, trig_src, fastcfg_enable, fastcfg_sync_enable,
		output fastcfg_chip_select, fastcfg_accumulator_auto_reset, phase_continuous_select,
		output accumulator_auto_reset, freq_word, phase_word, upconverter_gain_select, real_mode,
		output output_channel_source_select
	);
endinterface : nsb_link_if

// >>> shared/nsb_pkg.sv
// Types shared by both ends of the oscillator update and bonder link
// Assumes: compiled before the interface and the modules
package nsb_pkg;
	typedef enum logic [1:0] {
		NSB_TRIG_SYSREF = 2'h0,
		NSB_TRIG_SW = 2'h1,
		NSB_TRIG_FASTCFG = 2'h2,
		NSB_TRIG_LSB = 2'h3
	} nsb_trig_e;
	typedef enum logic [1:0] {
		NSB_PAT_IDLE = 2'h0,
		NSB_PAT_LOW = 2'h1,
		NSB_PAT_HIGH = 2'h3
	} nsb_pat_e;
	typedef logic signed [15:0] nsb_sample_t;
	typedef logic [63:0] nsb_freq_t;
	typedef logic [1:0] nsb_gain_t;
endpackage : nsb_pkg

// >>> testbench/nsb_checker.sv
// Concurrent checks on the APB side, the link and the device sync outputs
// Assumes: instantiated by the testbench beside the link, one clock domain
`timescale 1ns/10ps
module nsb_checker
	import nsb_pkg::*;
#(
	parameter int N_DUC = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pattern_busy,
	input nsb_pkg::nsb_sample_t [N_DUC-1:0] i_smp,
	input wire logic smp_valid,
	input wire logic sysref,
	input wire logic sw_sync,
	input nsb_pkg::nsb_trig_e trig_src,
	input wire logic fastcfg_enable,
	input wire logic fastcfg_sync_enable,
	input wire logic fastcfg_chip_select,
	input wire logic sync_event,
	input wire logic lsb_replace_active
);
	logic lo;
	logic hi;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Sync LSB seen low or high while register-path replacement is on
	assign lo = smp_valid && !i_smp[0][0] && sw_sync && trig_src == NSB_TRIG_LSB && !fastcfg_enable;
	assign hi = smp_valid && i_smp[0][0] && sw_sync && trig_src == NSB_TRIG_LSB && !fastcfg_enable;
	sync_pulse_a: assert property (sync_event |=> !sync_event)
		else $error("sync event longer than one cycle");
	sw_trigger_a: assert property ((trig_src == NSB_TRIG_SW && sw_sync && !$past(sw_sync)) |=> sync_event)
		else $error("software sync did not fire");
	sw_quiet_a: assert property (($stable(trig_src) && trig_src == NSB_TRIG_SW
		&& !(sw_sync && !$past(sw_sync))) |=> !sync_event)
		else $error("sync event without software edge");
	sysref_trigger_a: assert property ((trig_src == NSB_TRIG_SYSREF && $rose(sysref)) |=> sync_event)
		else $error("sysref pulse did not fire");
	cs_trigger_a: assert property ((trig_src == NSB_TRIG_FASTCFG && fastcfg_sync_enable
		&& $rose(fastcfg_chip_select)) |=> sync_event)
		else $error("chip select edge did not fire");
	cs_gated_a: assert property ((trig_src == NSB_TRIG_FASTCFG && $stable(trig_src)
		&& !fastcfg_sync_enable) |=> !sync_event)
		else $error("chip select fired without sync enable");
	replace_cond_a: assert property (lsb_replace_active |-> $past(sw_sync) && $past(trig_src) == NSB_TRIG_LSB)
		else $error("replacement active without its condition");
	lsb_fire_a: assert property (lo [*4] ##1 hi [*4] |=> sync_event)
		else $error("fourth high sample did not fire");
	lsb_early_a: assert property (lo [*4] ##1 hi [*3] |=> !sync_event)
		else $error("sync fired before the fourth high sample");
	pattern_len_a: assert property ($rose(pattern_busy) |-> pattern_busy [*8] ##1 !pattern_busy)
		else $error("pattern not eight cycles long");
	pattern_bits_a: assert property ($rose(pattern_busy) |->
		(i_smp[0][0] == 1'b0) [*4] ##1 (i_smp[0][0] == 1'b1) [*4])
		else $error("sync bit pattern not four low then four high");
	apb_wait_a: assert property ((psel && $rose(penable)) |=> pready)
		else $error("ready not in second access cycle");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	apb_err_a: assert property (pready |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
		else $error("error response does not match address");
endmodule : nsb_checker

// >>> testbench/testbench.sv
// Self-checking bench: APB master on the source end, monitor on the device end
// Assumes: package, interface and both design ends compiled before it
`timescale 1ns/10ps
`include "nsb_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	import nsb_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, pattern_busy, out_valid, sync_event, lsb_replace_active;
	logic [1:0] look;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [32:0] ex;
	logic [47:0] tab [6];
	nsb_sample_t [1:0] out_i, out_q;
	int errors, num_checks, cyc, last_edge;
	logic [32:0] rd_q[$], ev_q[$], dat_q[$];
	nsb_link_if nsb_link_if_i (.clk(clk));
	nsb_source_end nsb_source_end_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pattern_busy(pattern_busy), .link(nsb_link_if_i.src));
	nsb_device_end nsb_device_end_i (.clk(clk), .rst(rst), .link(nsb_link_if_i.dev), .out_i(out_i),
		.out_q(out_q), .out_valid(out_valid), .sync_event(sync_event), .lsb_replace_active(lsb_replace_active));
	nsb_checker nsb_checker_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
		.pready(pready), .pslverr(pslverr), .pattern_busy(pattern_busy), .i_smp(nsb_link_if_i.i_smp),
		.smp_valid(nsb_link_if_i.smp_valid), .sysref(nsb_link_if_i.sysref), .sw_sync(nsb_link_if_i.sw_sync),
		.trig_src(nsb_link_if_i.trig_src), .fastcfg_enable(nsb_link_if_i.fastcfg_enable),
		.fastcfg_sync_enable(nsb_link_if_i.fastcfg_sync_enable),
		.fastcfg_chip_select(nsb_link_if_i.fastcfg_chip_select), .sync_event(sync_event),
		.lsb_replace_active(lsb_replace_active));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic stop_test();
		// Notes never matched by a result count as misses
		errors += rd_q.size() + ev_q.size() + dat_q.size();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// Cycle count for event timing, and the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			stop_test();
		end
	end
	// Monitor: takes the oldest note whenever a result shows
	always @(posedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0) begin
			ex = rd_q.size() ? rd_q.pop_front() : 33'bx;
			`CHK({pslverr, prdata}, ex)
		end
		if (sync_event === 1'b1) begin
			ex = ev_q.size() ? ev_q.pop_front() : 33'bx;
			`CHK(33'(cyc), ex)
		end
		if (look !== 2'h0) begin
			ex = dat_q.size() ? dat_q.pop_front() : 33'bx;
			`CHK(look[1] ? {15'h0, lsb_replace_active} : out_i[0], ex[15:0])
			if (look[0]) `CHK(out_q[0], ex[31:16])
			`CHK(out_valid, 1'b1)
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		last_edge = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// Write control word, note the edge where the sync pulse must show
	task automatic ev(input logic [31:0] d, input int lat);
		apb(1'b1, `NSB_OFS_CTRL, d);
		if (lat > 0)
			ev_q.push_back(33'(last_edge + lat));
	endtask : ev
	// Note a value, then strobe the monitor once outputs have settled
	task automatic probe(input logic [1:0] k, input logic [31:0] e);
		repeat (8) @(posedge clk);
		dat_q.push_back(33'(e));
		look <= k;
		@(posedge clk);
		look <= 2'h0;
	endtask : probe
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		look = 2'h0;
		rnd = 32'h9523;
		tab = '{48'h00_55_7FFF_7FFE, 48'h20_55_7FFF_7FFF, 48'h00_00_7FFF_7FFF,
			48'h00_AA_7FFF_3FFF, 48'h00_00_8000_8000, 48'h20_AA_8000_8001};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`NSB_OFS_SRC, {9'h0, 16'h0, `NSB_SRC_RST});
		rd(`NSB_OFS_CTRL, 33'h0);
		rd(8'h24, 33'h1_0000_0000);
		rd(8'h02, 33'h1_0000_0000);
		wr(`NSB_OFS_MODE, 32'hFFFF_FA5C);
		rd(`NSB_OFS_MODE, 33'h0_0000_0A5C);
		$display("test registers done");
		repeat (4) begin
			rnd = lfsr(rnd);
			wr(`NSB_OFS_SAMPLE, rnd);
			probe(2'h1, {16'(($signed(rnd[31:16]) * 32767) >>> 15), 16'(($signed(rnd[15:0]) * 32767) >>> 15)});
		end
		$display("test unit gain done");
		wr(`NSB_OFS_SRC, 32'h2F);
		foreach (tab[k]) begin
			wr(`NSB_OFS_CTRL, 32'(tab[k][47:40]));
			wr(`NSB_OFS_GAIN, 32'(tab[k][39:32]));
			wr(`NSB_OFS_SAMPLE, 32'(tab[k][31:16]));
			probe(2'h1, 32'(tab[k][15:0]));
		end
		// Eighth-turn phase, input magnitude above full scale
		wr(`NSB_OFS_SRC, 32'h21);
		wr(`NSB_OFS_CTRL, 32'h0);
		wr(`NSB_OFS_GAIN, 32'h0);
		wr(`NSB_OFS_PHASE, 32'h2000);
		wr(`NSB_OFS_SAMPLE, 32'h8000_7FFF);
		probe(2'h1, 32'hFFFF_7FFF);
		$display("test bonder done");
		ev(32'h0000_0005, 2);
		ev(32'h0, 0);
		ev(32'h0001_0000, 2);
		ev(32'h0000_0002, 0);
		ev(32'h0000_0042, 0);
		ev(32'h0000_0012, 0);
		ev(32'h0000_0052, 2);
		ev(32'h0, 0);
		$display("test trigger sources done");
		ev(32'h0002_0007, 9);
		probe(2'h2, 16'h1);
		ev(32'h0, 0);
		probe(2'h2, 16'h0);
		ev(32'h0002_000F, 9);
		probe(2'h2, 16'h0);
		ev(32'h0, 0);
		$display("test lsb sync done");
		stop_test();
	end
endmodule : testbench
